// ===== dv/cdsb_dev_model.sv
// Behavioural device on the far side of the sample bus: makes the data clock,
// answers receive bursts and captures transmit samples for the bench to read.
// Assumes the pin structs of cdsb_pkg; the bench reads the counters directly.
`timescale 1ns/1ns
`default_nettype none
module cdsb_dev_model
  import cdsb_pkg::*;
(
  input  wire cdsb_pkg::cdsb_pin_out_s host_i,
  input  wire logic                    level_i,
  input  wire logic                    ddr_i,
  output var  cdsb_pkg::cdsb_pin_in_s  dev_o
);
  logic                dclk    = 1'b0;
  logic                busy    = 1'b0;
  logic                is_tx   = 1'b0;
  logic                en_q    = 1'b0;
  logic                fr_q    = 1'b0;
  logic                seen    = 1'b0;
  logic                nz_pre  = 1'b0;
  logic                dir_bad = 1'b0;
  logic                rxf     = 1'b0;
  logic                slot    = 1'b0;
  logic [SAMPLE_W-1:0] rxv     = '0;
  logic [SAMPLE_W-1:0] bus;
  logic [SAMPLE_W-1:0] cap [4];
  int                  n_cap   = 0;
  int                  n_rise  = 0;
  int                  n_rx    = 0;
  time                 t_last  = 0;
  time                 per     = 0;

  // Free running, phase unrelated to the host clock
  initial begin
    #3;
    forever #80 dclk = ~dclk;
  end

  // Whichever port the host drives is the active one
  always_comb bus = host_i.p1_oe[0] ? host_i.p1_o : host_i.p0_o;

  // Mid-cycle sampling equals a rising capture in SDR and avoids racing the
  // host, which launches on the same clock edge as the returned clock
  always @(negedge host_i.tx_return_clock) begin
    if (t_last != 0) per = $time - t_last;
    t_last = $time;
    if (level_i) busy = host_i.enable;
    else if (host_i.enable && !en_q) busy = !busy;
    if (host_i.enable && !en_q) is_tx = host_i.burst_direction_select;
    if (busy && host_i.burst_direction_select != is_tx) dir_bad = 1'b1;
    en_q = host_i.enable;
    if (host_i.tx_frame && !fr_q) begin
      seen = 1'b1;
      n_rise++;
    end
    if (host_i.p0_oe[0] || host_i.p1_oe[0]) begin
      if (!seen && bus != '0) nz_pre = 1'b1;
      if (seen && n_cap < 4) begin
        cap[n_cap] = bus;
        n_cap++;
      end
    end
    fr_q = host_i.tx_frame;
  end

  // DDR second capture: the value launched after the falling edge; a level
  // frame is already high when the first launch falls on that edge
  always @(posedge host_i.tx_return_clock) begin
    if (ddr_i && host_i.tx_frame && (host_i.p0_oe[0] || host_i.p1_oe[0]) && n_cap < 4) begin
      seen = 1'b1;
      cap[n_cap] = bus;
      n_cap++;
    end
  end

  // Receive burst: frame held high, two-slot pattern launched mid-cycle
  always @(negedge dclk) begin
    rxf = busy && !is_tx;
    if (!rxf) slot = 1'b0;
    rxv = slot ? 12'h0a5 : 12'h5a1;
    if (rxf) begin
      slot = !slot;
      n_rx++;
    end
  end

  // Outside a receive frame a released bus shows the inverse pattern, never a held value
  always_comb begin
    dev_o.data_clk = dclk;
    dev_o.rx_frame = rxf;
    dev_o.p0_i     = host_i.p0_oe[0] ? host_i.p0_o : (rxf ? rxv : ~rxv);
    dev_o.p1_i     = host_i.p1_oe[0] ? host_i.p1_o : (rxf ? rxv : ~rxv);
  end

  task clear();
    seen   = 1'b0;
    n_cap  = 0;
    n_rise = 0;
    n_rx   = 0;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking bench for the sample bus host: Wishbone classic tasks drive
// the controller, the device model answers on the pins.
// Assumes cdsb_host and cdsb_dev_model are compiled with cdsb_pkg.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cdsb_pkg::*;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          lvl   = 1'b0;
  logic          ddr   = 1'b0;
  cdsb_wb_req_s  wb_i  = '0;
  cdsb_wb_rsp_s  wb_o;
  cdsb_pin_in_s  pins_i;
  cdsb_pin_out_s pins_o;
  logic [31:0]   q;
  logic [7:0]    cfg [5] = '{8'h01, 8'h11, 8'h09, 8'h41, 8'h85};
  int            n_fail = 0;
  int            total_checks = 0;

  initial forever #5 clk_i = ~clk_i;

  cdsb_host dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o), .pins_i(pins_i), .pins_o(pins_o));
  cdsb_dev_model model_u (.host_i(pins_o), .level_i(lvl), .ddr_i(ddr), .dev_o(pins_i));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task results();
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Request held until ack is sampled high; released at that same edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_o.ack !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    q = wb_o.dat;
    wb_i <= '0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task wait_st(input logic [3:0] s);
    for (int i = 0; i < 100; i++) begin
      xfer(1'b0, OFF_STATUS, 32'h0);
      if (q[3:0] === s) break;
    end
    chk(32'(q[3:0]), 32'(s));
  endtask

  task tx_burst(input logic [7:0] c);
    lvl <= c[CTRL_LEVEL];
    ddr <= c[CTRL_DDR];
    wr(OFF_CTRL, {24'h0, c});
    for (int s = 0; s < 4; s++) wr(OFF_TX0 + 8'(4 * s), s[0] ? 32'h800 : 32'h7ff);
    model_u.clear();
    wr(OFF_CMD, 32'h05);
    wait_st(4'h4);
    chk(32'({pins_o.p1_oe, pins_o.p0_oe}), c[CTRL_SWAP] ? 32'hfff000 : 32'h000fff);
    chk(32'(pins_o.enable), 32'(c[CTRL_LEVEL]));
    wr(OFF_CTRL, 32'h00);
    rd(OFF_CTRL, {24'h0, c});
    for (int i = 0; i < 3000 && model_u.n_cap < 4; i++) @(posedge clk_i);
    chk(32'(model_u.cap[0]), 32'h7ff);
    chk(32'(model_u.cap[1]), 32'h800);
    chk(32'(model_u.cap[2]), 32'h7ff);
    chk(32'(model_u.nz_pre), 32'h0);
    chk(32'(model_u.is_tx), 32'h1);
    chk(32'(model_u.n_rise > 1), 32'(c[CTRL_FTOGGLE]));
    wr(OFF_CMD, 32'h06);
    wait_st(4'h1);
    chk(32'(model_u.busy), 32'h0);
    chk(32'(pins_o.enable), 32'h0);
  endtask

  initial begin
    #500000;
    chk(32'h1, 32'h0);
    results();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(32'({pins_o.enable, pins_o.tx_frame, pins_o.p0_oe, pins_o.p1_oe}), 32'h0);
    rd(OFF_CTRL, 32'h01);
    rd(OFF_STATUS, 32'h01);
    wr(8'h40, 32'hffff);
    rd(8'h40, 32'h0);
    for (int k = 0; k < 5; k++) tx_burst(cfg[k]);
    // Receive burst on port zero
    wr(OFF_CTRL, 32'h01);
    model_u.clear();
    wr(OFF_CMD, 32'h01);
    wait_st(4'h4);
    chk(32'({pins_o.p1_oe, pins_o.p0_oe}), 32'h0);
    for (int i = 0; i < 3000 && model_u.n_rx < 6; i++) @(posedge clk_i);
    rd(OFF_RX0, 32'h5a1);
    rd(OFF_RX0 + 8'h04, 32'h0a5);
    wr(OFF_CMD, 32'h02);
    wait_st(4'h1);
    chk(32'(model_u.dir_bad), 32'h0);
    // Frequency-division modes
    wr(OFF_CTRL, 32'h00);
    rd(OFF_CTRL, 32'h00);
    chk(32'({pins_o.p1_oe, pins_o.p0_oe}), 32'h000fff);
    wr(OFF_CTRL, 32'h02);
    wr(OFF_CMD, 32'h18);
    rd(OFF_CMD, 32'h18);
    chk(32'({pins_o.enable, pins_o.burst_direction_select}), 32'h3);
    wr(OFF_CMD, 32'h08);
    rd(OFF_CMD, 32'h08);
    chk(32'({pins_o.enable, pins_o.burst_direction_select}), 32'h2);
    chk(32'(model_u.per), 32'ha0);
    results();
  end
endmodule
`default_nettype wire

// ===== verilog/cdsb_host.sv
// Host (baseband side) controller for a dual 12-bit CMOS I/Q sample bus.
// Assumes the device's data clock and frame arrive asynchronously on pins and
// that software drives it over a Wishbone classic slave port.
//
// Functional notes
// - two 12-bit ports, one or both used
// - FDD: port zero transmits, port one receives
// - TDD: both directions share pins in turns
// - return clock copies data clock exactly
// - tx frame held high or toggling 50%
// - FDD independent: frame low flushes with zeros
// - enable pulse spans a link cycle, twice
// - direction steady for the whole burst
// - direction changes only while idle
// - FDD normal: direction ignored, held valid
// - rx data qualified by rx frame
// - two's complement, bit 11 sign
// - I/Q interleave, two or four slots
//
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module cdsb_host (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire cdsb_pkg::cdsb_wb_req_s  wb_i,
  output var  cdsb_pkg::cdsb_wb_rsp_s  wb_o,
  input  wire cdsb_pkg::cdsb_pin_in_s  pins_i,
  output var  cdsb_pkg::cdsb_pin_out_s pins_o
);
  import cdsb_pkg::*;

  typedef struct packed {
    cdsb_cfg_s                      cfg;
    logic                           dir_req;
    logic                           rx_on;
    logic                           tx_on;
    logic                           start_req;
    logic                           stop_req;
    cdsb_burst_e                    burst;
    logic                           burst_tx;
    logic [1:0]                     hold;
    logic [NSLOT-1:0][SAMPLE_W-1:0] tx_slots;
    logic [NSLOT-1:0][SAMPLE_W-1:0] rx_slots;
    logic [1:0]                     slot;
    logic [1:0]                     fpos;
    logic [1:0]                     rslot;
    logic                           tx_live;
    logic                           rx_live;
    logic                           rfrm_prev;
    logic [15:0]                    rx_frames;
    logic                           clk_s1;
    logic                           clk_s2;
    logic                           clk_s3;
    logic                           frm_s1;
    logic                           frm_s2;
    logic [SAMPLE_W-1:0]            p0_s1;
    logic [SAMPLE_W-1:0]            p0_s2;
    logic [SAMPLE_W-1:0]            p1_s1;
    logic [SAMPLE_W-1:0]            p1_s2;
    logic                           enable;
    logic                           dir;
    logic                           tx_frame;
    logic [SAMPLE_W-1:0]            p0_o;
    logic [SAMPLE_W-1:0]            p1_o;
    logic                           p0_oe;
    logic                           p1_oe;
    logic                           ack;
    logic [31:0]                    rdat;
  } cdsb_state_s;

  cdsb_state_s st_reg;
  cdsb_state_s st_next;

  logic       indep;
  logic       rise;
  logic       xfer;
  logic       act_tx;
  logic       act_rx;
  logic       tdd2;
  logic [1:0] step;
  logic [1:0] smask;
  logic [1:0] flen;
  logic       use_p1;
  logic [5:0] widx;
  logic [1:0] nslot;
  logic [1:0] nrslot;
  logic [1:0] nfpos;

  always_comb begin
    st_next = st_reg;
    widx    = wb_i.adr[7:2];
    indep   = (st_reg.cfg.mode == MODE_FDD_INDEP);
    tdd2    = (st_reg.cfg.mode == MODE_TDD) && st_reg.cfg.two_port;
    use_p1  = (st_reg.cfg.mode == MODE_TDD) && !st_reg.cfg.two_port && st_reg.cfg.swap;
    step    = tdd2 ? 2'h2 : 2'h1;
    smask   = st_reg.cfg.two_chan ? 2'h3 : 2'h1;
    flen    = (st_reg.cfg.two_chan && !tdd2) ? 2'h3 : 2'h1;
    nslot   = 2'h0;
    nrslot  = 2'h0;
    nfpos   = 2'h0;

    // Only the later stages feed logic (clk_s2 and clk_s3 for the edge detect); the first is a pure synchroniser
    st_next.clk_s1 = pins_i.data_clk;
    st_next.clk_s2 = st_reg.clk_s1;
    st_next.clk_s3 = st_reg.clk_s2;
    st_next.frm_s1 = pins_i.rx_frame;
    st_next.frm_s2 = st_reg.frm_s1;
    st_next.p0_s1  = pins_i.p0_i;
    st_next.p0_s2  = st_reg.p0_s1;
    st_next.p1_s1  = pins_i.p1_i;
    st_next.p1_s2  = st_reg.p1_s1;
    rise = st_reg.clk_s2 & ~st_reg.clk_s3;
    xfer = rise | (st_reg.cfg.ddr & ~st_reg.clk_s2 & st_reg.clk_s3);

    // Wishbone slave: ack one cycle after the request, dropped the next cycle
    st_next.ack = wb_i.cyc & wb_i.stb & ~st_reg.ack;
    if (wb_i.cyc && wb_i.stb && !st_reg.ack) begin
      st_next.rdat = 32'h0;
      case ({widx, 2'b00})
        OFF_CTRL:   st_next.rdat = {24'h0, st_reg.cfg};
        OFF_CMD:    st_next.rdat = {27'h0, st_reg.tx_on, st_reg.rx_on, st_reg.dir_req, 2'b00};
        OFF_STATUS: st_next.rdat = {st_reg.rx_frames, 8'h0, st_reg.tx_live, st_reg.rx_live,
                                    st_reg.burst_tx, st_reg.dir, st_reg.burst};
        default: begin
          // Slot banks decode on address bits 7:4, the slot index on bits 3:2
          if (widx[5:2] == OFF_TX0[7:4]) begin
            st_next.rdat = {20'h0, st_reg.tx_slots[widx[1:0]]};
          end else if (widx[5:2] == OFF_RX0[7:4]) begin
            st_next.rdat = {20'h0, st_reg.rx_slots[widx[1:0]]};
          end
        end
      endcase
      if (wb_i.we && wb_i.sel[0]) begin
        case ({widx, 2'b00})
          OFF_CTRL: begin
            // Reconfiguring mid-burst would tear the bus; only taken while idle
            if (st_reg.burst == ST_IDLE) begin
              st_next.cfg = wb_i.dat[7:0];
            end
          end
          OFF_CMD: begin
            if (st_reg.burst == ST_IDLE) begin
              st_next.dir_req   = wb_i.dat[CMD_DIR];
              st_next.start_req = wb_i.dat[CMD_START] | st_reg.start_req;
            end
            st_next.stop_req = (wb_i.dat[CMD_STOP] && st_reg.burst != ST_IDLE) | st_reg.stop_req;
            st_next.rx_on    = wb_i.dat[CMD_RX_ON];
            st_next.tx_on    = wb_i.dat[CMD_TX_ON];
          end
          default: begin
            if (widx[5:2] == OFF_TX0[7:4] && wb_i.sel[1]) begin
              st_next.tx_slots[widx[1:0]] = wb_i.dat[SAMPLE_W-1:0];
            end
          end
        endcase
      end
    end

    // Burst control
    case (st_reg.burst)
      ST_IDLE: begin
        st_next.hold = 2'h0;
        if (indep) begin
          st_next.enable = st_reg.rx_on;
          st_next.dir    = st_reg.tx_on;
        end else begin
          st_next.dir = st_reg.dir_req;
          if (st_reg.start_req) begin
            st_next.start_req = 1'b0;
            st_next.enable    = 1'b1;
            st_next.burst     = ST_ON;
            st_next.burst_tx  = (st_reg.cfg.mode == MODE_TDD) ? st_reg.dir_req : 1'b1;
          end
        end
      end
      ST_ON: begin
        if (rise) begin
          st_next.hold = st_reg.hold + 2'h1;
          if (st_reg.hold + 2'h1 == PULSE_RISES) begin
            st_next.burst  = ST_ACT;
            st_next.hold   = 2'h0;
            st_next.enable = st_reg.cfg.level;
          end
        end
      end
      ST_ACT: begin
        if (st_reg.stop_req) begin
          st_next.stop_req = 1'b0;
          st_next.burst    = ST_OFF;
          st_next.enable   = ~st_reg.cfg.level;
        end
      end
      ST_OFF: begin
        if (rise) begin
          st_next.hold = st_reg.hold + 2'h1;
          if (st_reg.hold + 2'h1 == PULSE_RISES) begin
            st_next.burst  = ST_IDLE;
            st_next.hold   = 2'h0;
            st_next.enable = 1'b0;
          end
        end
      end
      default: begin
        st_next.burst  = ST_IDLE;
        st_next.enable = 1'b0;
      end
    endcase

    act_tx = indep ? st_reg.tx_on
                   : (st_reg.burst == ST_ACT) && (st_reg.cfg.mode == MODE_FDD || st_reg.burst_tx);
    // Receive tracking opens with the start pulse so an early rx frame rise is not missed
    act_rx = indep ? st_reg.rx_on
                   : (st_reg.burst == ST_ON || st_reg.burst == ST_ACT)
                     && (st_reg.cfg.mode == MODE_FDD || !st_reg.burst_tx);

    // Drive enables: FDD port zero is ours, port one is the device's
    if (st_reg.cfg.mode == MODE_TDD) begin
      st_next.p0_oe = act_tx && !use_p1;
      st_next.p1_oe = act_tx && (use_p1 || st_reg.cfg.two_port);
    end else begin
      st_next.p0_oe = 1'b1;
      st_next.p1_oe = 1'b0;
    end

    // Transmit launch
    if (!act_tx) begin
      st_next.tx_live  = 1'b0;
      st_next.tx_frame = 1'b0;
      st_next.p0_o     = '0;
      st_next.p1_o     = '0;
    end else if (xfer) begin
      if (st_reg.tx_live) begin
        nslot = (st_reg.slot + step) & smask;
        nfpos = (st_reg.fpos + 2'h1) & flen;
      end
      st_next.tx_live  = 1'b1;
      st_next.slot     = nslot;
      st_next.fpos     = nfpos;
      st_next.tx_frame = st_reg.cfg.ftoggle ? (nfpos <= (flen >> 1)) : 1'b1;
      st_next.p0_o     = use_p1 ? '0 : st_reg.tx_slots[nslot];
      st_next.p1_o     = tdd2 ? st_reg.tx_slots[(nslot + 2'h1) & smask]
                              : (use_p1 ? st_reg.tx_slots[nslot] : '0);
    end

    // Receive capture, qualified by the device's frame marker
    if (!act_rx) begin
      st_next.rx_live   = 1'b0;
      st_next.rfrm_prev = 1'b0;
    end else if (xfer) begin
      st_next.rfrm_prev = st_reg.frm_s2;
      if (st_reg.frm_s2 && !st_reg.rfrm_prev) begin
        nrslot = 2'h0;
        st_next.rx_live   = 1'b1;
        st_next.rx_frames = st_reg.rx_frames + 16'h1;
      end else begin
        nrslot = (st_reg.rslot + step) & smask;
      end
      if (st_next.rx_live) begin
        st_next.rslot = nrslot;
        if (st_reg.cfg.mode != MODE_TDD || use_p1) begin
          st_next.rx_slots[nrslot] = st_reg.p1_s2;
        end else begin
          st_next.rx_slots[nrslot] = st_reg.p0_s2;
          if (tdd2) begin
            st_next.rx_slots[(nrslot + 2'h1) & smask] = st_reg.p1_s2;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg       <= '0;
      st_reg.cfg   <= CTRL_RESET;
      st_reg.burst <= ST_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    wb_o.ack                      = st_reg.ack;
    wb_o.dat                      = st_reg.rdat;
    pins_o.tx_return_clock        = st_reg.clk_s2;
    pins_o.tx_frame               = st_reg.tx_frame;
    pins_o.enable                 = st_reg.enable;
    pins_o.burst_direction_select = st_reg.dir;
    pins_o.p0_o                   = st_reg.p0_o;
    pins_o.p1_o                   = st_reg.p1_o;
    pins_o.p0_oe                  = {SAMPLE_W{st_reg.p0_oe}};
    pins_o.p1_oe                  = {SAMPLE_W{st_reg.p1_oe}};
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Both synchroniser stages must have left reset before the copy is exact
  a_ret_clk_copy: assert property (!$past(rst_i) && !$past(rst_i, 2) |->
    pins_o.tx_return_clock == $past(pins_i.data_clk, 2)) else $error("return clock not a copy");
  a_enable_held: assert property (st_reg.burst == ST_ON |-> st_reg.enable)
    else $error("enable dropped before pulse end");
  a_pulse_two_rises: assert property ($rose(st_reg.burst == ST_ACT) && !st_reg.cfg.level |->
    $past(st_reg.hold) == 2'h1 && $past(rise)) else $error("enable pulse too short");
  a_dir_steady: assert property (!indep && st_reg.burst != ST_IDLE && $past(st_reg.burst) != ST_IDLE
    |-> $stable(st_reg.dir)) else $error("direction moved during burst");
  a_dir_idle_only: assert property ($changed(st_reg.dir) && !indep |->
    $past(st_reg.burst) == ST_IDLE) else $error("direction changed outside idle");
  a_fdd_flush: assert property (!st_reg.tx_live |-> !st_reg.tx_frame && st_reg.p0_o == '0
    && st_reg.p1_o == '0) else $error("nonzero data outside tx frame");
  a_frame_start: assert property ($rose(st_reg.tx_live) |-> st_reg.tx_frame && st_reg.slot == 2'h0)
    else $error("tx frame not rising at slot zero");
  // Enables are registered from the previous cycle's burst state
  a_one_driver: assert property ($past(st_reg.cfg.mode) == MODE_TDD && (st_reg.p0_oe || st_reg.p1_oe) |->
    $past(st_reg.burst) == ST_ACT && $past(st_reg.burst_tx)) else $error("host drives during rx");
  a_indep_map: assert property (indep && st_reg.burst == ST_IDLE |=> st_reg.enable == $past(st_reg.rx_on)
    && st_reg.dir == $past(st_reg.tx_on)) else $error("independent control mismatch");
  a_rx_qualified: assert property ($changed(st_reg.rx_slots) |-> st_reg.rx_live)
    else $error("rx stored without frame");
  a_wb_ack_once: assert property (st_reg.ack |=> !st_reg.ack) else $error("ack held twice");
  a_burst_onehot: assert property ($onehot(st_reg.burst)) else $error("burst state not one-hot");

  c_tx_burst: cover property ($rose(st_reg.tx_live) && st_reg.cfg.mode == MODE_TDD);
  c_rx_frame: cover property ($changed(st_reg.rx_frames));
  c_ddr_xfer: cover property (st_reg.cfg.ddr && xfer && !rise && st_reg.tx_live);
  c_indep_tx: cover property (indep && $rose(st_reg.tx_live));
endmodule
`default_nettype wire

// ===== verilog/cdsb_pkg.sv
// Package for the host-side controller of a dual 12-bit CMOS sample bus.
// Assumes a Wishbone classic slave port with byte addresses and 32-bit data.
package cdsb_pkg;

  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned NSLOT    = 4;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CMD    = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_TX0    = 8'h10;
  localparam logic [7:0] OFF_RX0    = 8'h20;

  // Control field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_DDR      = 2;
  localparam int unsigned CTRL_LEVEL    = 3;
  localparam int unsigned CTRL_FTOGGLE  = 4;
  localparam int unsigned CTRL_TWO_PORT = 5;
  localparam int unsigned CTRL_SWAP     = 6;
  localparam int unsigned CTRL_TWO_CHAN = 7;

  // Command field positions
  localparam int unsigned CMD_START = 0;
  localparam int unsigned CMD_STOP  = 1;
  localparam int unsigned CMD_DIR   = 2;
  localparam int unsigned CMD_RX_ON = 3;
  localparam int unsigned CMD_TX_ON = 4;

  // Duplex modes
  localparam logic [1:0] MODE_FDD       = 2'h0;
  localparam logic [1:0] MODE_TDD       = 2'h1;
  localparam logic [1:0] MODE_FDD_INDEP = 2'h2;

  localparam logic [7:0] CTRL_RESET = 8'h01;
  // Link rising edges that the enable pulse and the finish wait span
  localparam logic [1:0] PULSE_RISES = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ON   = 4'b0010,
    ST_ACT  = 4'b0100,
    ST_OFF  = 4'b1000
  } cdsb_burst_e;

  typedef struct packed {
    logic        two_chan;
    logic        swap;
    logic        two_port;
    logic        ftoggle;
    logic        level;
    logic        ddr;
    logic [1:0]  mode;
  } cdsb_cfg_s;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } cdsb_wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } cdsb_wb_rsp_s;

  typedef struct packed {
    logic                data_clk;
    logic                rx_frame;
    logic [SAMPLE_W-1:0] p0_i;
    logic [SAMPLE_W-1:0] p1_i;
  } cdsb_pin_in_s;

  typedef struct packed {
    logic                tx_return_clock;
    logic                tx_frame;
    logic                enable;
    logic                burst_direction_select;
    logic [SAMPLE_W-1:0] p0_o;
    logic [SAMPLE_W-1:0] p0_oe;
    logic [SAMPLE_W-1:0] p1_o;
    logic [SAMPLE_W-1:0] p1_oe;
  } cdsb_pin_out_s;

endpackage
